/* core/ilpc_cfg.svh */
// constants for the interrupt and low power controller
// assumes a core clock of 40 MHz and an 8-bit data space write port
//
// Overview of operation
// - three carry/zero flag copies: normal, interrupt, nmi; chosen automatically
// - on entry: switch flag set, push pc, clear first latch, load vector
// - during a maskable routine block maskable lines, still accept nmi
// - return restores previous flag set and pops the saved pc
// - option register write-only at 0C8h, ignores single-bit set/clear
// - option register clears to 00h on any reset
// - bit 6 one makes source 1 level sensitive, zero edge sensitive
// - bit 5 selects which edge of source 2 raises a request
// - bit 4 one enables all; zero disables maskable, nmi still serviced
// - with bit 4 zero nmi is serviced but never wakes from wait/stop
// - timer underflow and converter end, each gated, go to vector 4
// - reload timer overflow, compare, edge, each gated, go to vector 3
// - serial end and port c to vector 2; ports a and b to vector 1
// - wait halts instructions at once, oscillator and peripherals keep running
// - interrupt wake from wait resumes with no stabilisation delay
// - pin or watchdog reset during wait performs the normal reset sequence
// - stop permitted only while watchdog is inactive
// - stop halts oscillator and instructions; exits only on nmi, a vector 1 or vector 2 request (serial end included) or reset
// - interrupt exit from stop inserts an oscillator stabilisation delay
// - polarity bit one means rising edges on source 2, zero falling
// - lines sampled at instruction end; a request replaces the next instruction
// - an active watchdog turns a stop instruction into a wait
// - wait or stop not entered while an enabled request is pending
`ifndef ILPC_CFG_SVH
`define ILPC_CFG_SVH
`define ILPC_OPT_ADDR 8'hC8
`define ILPC_OPT_RESET 8'h00
`define ILPC_BIT_LVL 6
`define ILPC_BIT_POL 5
`define ILPC_BIT_GIE 4
`define ILPC_OPT_MASK 8'h70
`define ILPC_CLK_MHZ 40
`define ILPC_STAB_US 2048
`define ILPC_VEC_NMI 12'hFFC
`define ILPC_VEC_1 12'hFF6
`define ILPC_VEC_2 12'hFF4
`define ILPC_VEC_3 12'hFF2
`define ILPC_VEC_4 12'hFF0
`endif

/* core/ilpc_pkg.sv */
// types for the interrupt and low power controller
// assumes ilpc_cfg.svh is available on the include path
package ilpc_pkg;
  typedef enum logic [3:0] {
    ILPC_RUN = 4'b0001,
    ILPC_WAIT = 4'b0010,
    ILPC_STOP = 4'b0100,
    ILPC_STAB = 4'b1000
  } ilpc_pwr_type;
  typedef enum logic [2:0] {
    ILPC_MODE_NORM = 3'b001,
    ILPC_MODE_INT = 3'b010,
    ILPC_MODE_NMI = 3'b100
  } ilpc_mode_type;
endpackage

/* core/ilpc_sync.sv */
// two flip-flop synchroniser for pin inputs
// assumes inputs asynchronous to the core clock
`timescale 1ns/1ps
module ilpc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  initial begin
    if (WIDTH < 1) $error("width must be positive");
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* core/ilpc_top.sv */
// interrupt sequencing, flag banks, option register and wait/stop control
// assumes the core strobes instruction end, return, wait and stop on CORE_CLK
`timescale 1ns/1ps
`include "ilpc_cfg.svh"
module ilpc_top
  import ilpc_pkg::*;
#(
  parameter int STACK_DEPTH = 6,
  parameter int PORT_W = 8,
  parameter int STAB_CYCLES = `ILPC_STAB_US * `ILPC_CLK_MHZ
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // data space write port
  input wire logic WR_EN,
  input wire logic WR_BIT_OP,
  input wire logic [7:0] WR_ADDR,
  input wire logic [7:0] WR_DATA,
  // core sequencing
  input wire logic INSTR_END,
  input wire logic RETURN_FROM_INTERRUPT,
  input wire logic WAIT_INSTR,
  input wire logic STOP_INSTR,
  input wire logic [11:0] PC_IN,
  output logic [11:0] PC_LOAD_VALUE,
  output logic PC_LOAD,
  output logic CORE_HALT,
  output logic OSC_STOP,
  // flags
  input wire logic FLAG_WR,
  input wire logic CARRY_IN,
  input wire logic ZERO_IN,
  output logic CARRY_OUT,
  output logic ZERO_OUT,
  output logic [2:0] CORE_MODE,
  // watchdog
  input wire logic WATCHDOG_ACTIVE,
  // external pins
  input wire logic NMI_N,
  input wire logic SRC1_PIN_N,
  input wire logic SRC2_PIN,
  input wire logic [PORT_W-1:0] PORT_A_IRQ,
  input wire logic [PORT_W-1:0] PORT_B_IRQ,
  input wire logic [PORT_W-1:0] PORT_C_IRQ,
  // peripheral events
  input wire logic TIMER_UNDERFLOW_FLAG,
  input wire logic TIMER_IRQ_ENABLE,
  input wire logic ADC_EOC_FLAG,
  input wire logic CONVERTER_IRQ_ENABLE,
  input wire logic RELOAD_TIMER_OVERFLOW_FLAG,
  input wire logic RELOAD_TIMER_OVERFLOW_ENABLE,
  input wire logic RELOAD_TIMER_COMPARE_FLAG,
  input wire logic RELOAD_TIMER_COMPARE_ENABLE,
  input wire logic RELOAD_TIMER_EDGE_FLAG,
  input wire logic RELOAD_TIMER_EDGE_ENABLE,
  input wire logic SERIAL_DONE_FLAG,
  input wire logic SERIAL_IRQ_ENABLE
);
  // ************************************
  // checks and synchronisers
  // ************************************
  localparam int PTR_W = $clog2(STACK_DEPTH + 1);
  initial begin
    if (STACK_DEPTH < 2) $error("stack depth too small");
    if (STAB_CYCLES < 1) $error("stabilisation count must be positive");
  end
  logic [2:0] pin_s;
  logic [3*PORT_W-1:0] port_s;
  ilpc_sync #(.WIDTH(3)) u_pin_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .d({NMI_N, SRC1_PIN_N, SRC2_PIN}),
    .q(pin_s)
  );
  ilpc_sync #(.WIDTH(3 * PORT_W)) u_port_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .d({PORT_C_IRQ, PORT_B_IRQ, PORT_A_IRQ}),
    .q(port_s)
  );
  logic nmi_n_s, src1_n_s, src2_s;
  assign nmi_n_s = pin_s[2];
  assign src1_n_s = pin_s[1];
  assign src2_s = pin_s[0];
  // ************************************
  // option register
  // ************************************
  logic [7:0] opt_r;
  logic opt_wr;
  assign opt_wr = WR_EN && !WR_BIT_OP && (WR_ADDR == `ILPC_OPT_ADDR);
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      opt_r <= `ILPC_OPT_RESET;
    end else if (opt_wr) begin
      opt_r <= WR_DATA & `ILPC_OPT_MASK;
    end
  end
  logic level_edge_select, edge_polarity_select, global_interrupt_enable;
  assign level_edge_select = opt_r[`ILPC_BIT_LVL];
  assign edge_polarity_select = opt_r[`ILPC_BIT_POL];
  assign global_interrupt_enable = opt_r[`ILPC_BIT_GIE];
  // ************************************
  // request latches
  // ************************************
  logic nmi_d_r, src1_d_r, src2_d_r;
  logic nmi_lat_r, src1_lat_r, src2_lat_r;
  logic nmi_edge, src1_edge, src2_edge;
  logic take_nmi, take_1, take_2;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      nmi_d_r <= 1'b0;
      src1_d_r <= 1'b0;
      src2_d_r <= 1'b0;
    end else begin
      nmi_d_r <= nmi_n_s;
      src1_d_r <= src1_n_s;
      src2_d_r <= src2_s;
    end
  end
  assign nmi_edge = nmi_d_r && !nmi_n_s;
  assign src1_edge = src1_d_r && !src1_n_s;
  assign src2_edge = edge_polarity_select ? (!src2_d_r && src2_s) : (src2_d_r && !src2_s);
  // set wins over the clear by entry
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      nmi_lat_r <= 1'b0;
    end else if (nmi_edge) begin
      nmi_lat_r <= 1'b1;
    end else if (take_nmi) begin
      nmi_lat_r <= 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      src1_lat_r <= 1'b0;
      src2_lat_r <= 1'b0;
    end else begin
      if (src1_edge && !level_edge_select) begin
        src1_lat_r <= 1'b1;
      end else if (take_1 || level_edge_select) begin
        src1_lat_r <= 1'b0;
      end
      if (src2_edge) begin
        src2_lat_r <= 1'b1;
      end else if (take_2) begin
        src2_lat_r <= 1'b0;
      end
    end
  end
  // ************************************
  // source mapping
  // ************************************
  logic req1, req2, req3, req4, mask_req;
  assign req1 = (level_edge_select ? !src1_n_s : src1_lat_r) || (|port_s[2*PORT_W-1:0]);
  assign req2 = src2_lat_r || (|port_s[3*PORT_W-1:2*PORT_W]) || (SERIAL_DONE_FLAG && SERIAL_IRQ_ENABLE);
  assign req3 = (RELOAD_TIMER_OVERFLOW_FLAG && RELOAD_TIMER_OVERFLOW_ENABLE)
    || (RELOAD_TIMER_COMPARE_FLAG && RELOAD_TIMER_COMPARE_ENABLE)
    || (RELOAD_TIMER_EDGE_FLAG && RELOAD_TIMER_EDGE_ENABLE);
  assign req4 = (TIMER_UNDERFLOW_FLAG && TIMER_IRQ_ENABLE) || (ADC_EOC_FLAG && CONVERTER_IRQ_ENABLE);
  assign mask_req = global_interrupt_enable && (req1 || req2 || req3 || req4);
  // ************************************
  // mode, flag banks and stack
  // ************************************
  ilpc_mode_type mode_r;
  ilpc_pwr_type pwr_r;
  logic [2:0] bank_c_r, bank_z_r;
  logic prev_int_r;
  logic [11:0] stack_r [STACK_DEPTH];
  logic [PTR_W-1:0] sp_r;
  logic sample, entry, mask_ok, do_ret;
  logic [11:0] vec;
  assign sample = INSTR_END && (pwr_r == ILPC_RUN);
  assign mask_ok = (mode_r == ILPC_MODE_NORM) && mask_req;
  assign take_nmi = sample && (nmi_lat_r && mode_r != ILPC_MODE_NMI);
  assign take_1 = sample && !take_nmi && mask_ok && req1;
  assign take_2 = sample && !take_nmi && mask_ok && !req1 && req2;
  assign entry = take_nmi || (sample && mask_ok);
  assign do_ret = RETURN_FROM_INTERRUPT && (pwr_r == ILPC_RUN) && mode_r != ILPC_MODE_NORM;
  always_comb begin
    vec = `ILPC_VEC_4;
    if (take_nmi) vec = `ILPC_VEC_NMI;
    else if (req1) vec = `ILPC_VEC_1;
    else if (req2) vec = `ILPC_VEC_2;
    else if (req3) vec = `ILPC_VEC_3;
  end
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mode_r <= ILPC_MODE_NORM;
      prev_int_r <= 1'b0;
    end else if (entry) begin
      prev_int_r <= (mode_r == ILPC_MODE_INT);
      mode_r <= take_nmi ? ILPC_MODE_NMI : ILPC_MODE_INT;
    end else if (do_ret) begin
      if (mode_r == ILPC_MODE_NMI && prev_int_r) mode_r <= ILPC_MODE_INT;
      else mode_r <= ILPC_MODE_NORM;
      prev_int_r <= 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bank_c_r <= 3'h0;
      bank_z_r <= 3'h0;
    end else if (FLAG_WR) begin
      for (int i = 0; i < 3; i++) begin
        if (mode_r[i]) begin
          bank_c_r[i] <= CARRY_IN;
          bank_z_r[i] <= ZERO_IN;
        end
      end
    end
  end
  assign CARRY_OUT = |(bank_c_r & mode_r);
  assign ZERO_OUT = |(bank_z_r & mode_r);
  assign CORE_MODE = mode_r;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sp_r <= '0;
      PC_LOAD <= 1'b0;
      PC_LOAD_VALUE <= 12'h000;
    end else begin
      PC_LOAD <= entry || do_ret;
      if (entry) begin
        for (int i = STACK_DEPTH - 1; i > 0; i--) stack_r[i] <= stack_r[i-1];
        stack_r[0] <= PC_IN;
        if (sp_r < PTR_W'(STACK_DEPTH)) sp_r <= sp_r + 1'b1;
        PC_LOAD_VALUE <= vec;
      end else if (do_ret) begin
        for (int i = 0; i < STACK_DEPTH - 1; i++) stack_r[i] <= stack_r[i+1];
        if (sp_r != '0) sp_r <= sp_r - 1'b1;
        PC_LOAD_VALUE <= stack_r[0];
      end
    end
  end
  // ************************************
  // wait and stop
  // ************************************
  logic wake_wait, wake_stop, want_stop, want_lp;
  localparam int STAB_W = $clog2(STAB_CYCLES + 1);
  logic [STAB_W-1:0] stab_r;
  assign want_lp = (WAIT_INSTR || STOP_INSTR) && (pwr_r == ILPC_RUN) && !mask_req && !nmi_lat_r;
  assign want_stop = STOP_INSTR && !WATCHDOG_ACTIVE;
  assign wake_wait = global_interrupt_enable && (mask_req || nmi_lat_r);
  assign wake_stop = global_interrupt_enable && (nmi_lat_r || req1 || req2);
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pwr_r <= ILPC_RUN;
      stab_r <= '0;
    end else begin
      case (pwr_r)
        ILPC_RUN: begin
          if (want_lp) pwr_r <= want_stop ? ILPC_STOP : ILPC_WAIT;
        end
        ILPC_WAIT: begin
          if (wake_wait) pwr_r <= ILPC_RUN;
        end
        ILPC_STOP: begin
          if (wake_stop) begin
            pwr_r <= ILPC_STAB;
            stab_r <= '0;
          end
        end
        ILPC_STAB: begin
          if (stab_r == STAB_W'(STAB_CYCLES - 1)) pwr_r <= ILPC_RUN;
          else stab_r <= stab_r + 1'b1;
        end
        default: pwr_r <= ILPC_RUN;
      endcase
    end
  end
  assign CORE_HALT = (pwr_r != ILPC_RUN) || (want_lp);
  assign OSC_STOP = (pwr_r == ILPC_STOP);
  // ************************************
  // assertions
  // ************************************
  property p_opt_reset;
    @(posedge CORE_CLK) RST |=> opt_r == `ILPC_OPT_RESET;
  endproperty
  a_opt_reset: assert property (p_opt_reset) else $error("option not cleared by reset");
  property p_bitop_ignored;
    @(posedge CORE_CLK) disable iff (RST) (WR_EN && WR_BIT_OP) |=> $stable(opt_r);
  endproperty
  a_bitop_ignored: assert property (p_bitop_ignored) else $error("bit operation changed option");
  property p_unused_zero;
    @(posedge CORE_CLK) disable iff (RST) (opt_r & ~`ILPC_OPT_MASK) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused option bit set");
  property p_entry_vec;
    @(posedge CORE_CLK) disable iff (RST) take_nmi |=> PC_LOAD && PC_LOAD_VALUE == `ILPC_VEC_NMI && stack_r[0] == $past(PC_IN);
  endproperty
  a_entry_vec: assert property (p_entry_vec) else $error("nmi entry wrong");
  property p_mask_block;
    @(posedge CORE_CLK) disable iff (RST) (mode_r != ILPC_MODE_NORM) |-> !(take_1 || take_2);
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("nested maskable entry");
  property p_enable_off;
    @(posedge CORE_CLK) disable iff (RST) (!global_interrupt_enable && pwr_r == ILPC_WAIT) |=> pwr_r != ILPC_RUN;
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("woke with global enable low");
  property p_wd_no_stop;
    @(posedge CORE_CLK) disable iff (RST) (pwr_r == ILPC_RUN && WATCHDOG_ACTIVE) |=> pwr_r != ILPC_STOP;
  endproperty
  a_wd_no_stop: assert property (p_wd_no_stop) else $error("stop with watchdog active");
  property p_wait_fast;
    @(posedge CORE_CLK) disable iff (RST) (pwr_r == ILPC_WAIT && wake_wait) |=> pwr_r == ILPC_RUN;
  endproperty
  a_wait_fast: assert property (p_wait_fast) else $error("wait wake delayed");
  property p_stop_stab;
    @(posedge CORE_CLK) disable iff (RST) (pwr_r == ILPC_STOP && wake_stop) |=> pwr_r == ILPC_STAB && CORE_HALT;
  endproperty
  a_stop_stab: assert property (p_stop_stab) else $error("stop wake skipped delay");
  property p_no_lp_pending;
    @(posedge CORE_CLK) disable iff (RST) (pwr_r == ILPC_RUN && mask_req) |=> pwr_r == ILPC_RUN;
  endproperty
  a_no_lp_pending: assert property (p_no_lp_pending) else $error("low power with request pending");
endmodule

/* tb/ilpc_core_model.sv */
// core-side partner: instruction end and return pulses, follows pc loads
// assumes the controller answers on the same core clock
`timescale 1ns/1ps
module ilpc_core_model (
  // clock
  input wire logic clk,
  // core sequencing
  output logic instr_end,
  output logic ret_pulse,
  output logic [11:0] pc,
  input wire logic [11:0] pc_load_value,
  input wire logic pc_load
);
  initial begin
    instr_end = 1'b0;
    ret_pulse = 1'b0;
    pc = 12'h123;
  end
  // pc only moves on a load, so the pushed value is known
  always @(posedge clk) begin
    if (pc_load) begin
      pc <= pc_load_value;
    end
  end
  // one-cycle pulse of instruction end or return
  task automatic pulse(input logic is_ret);
    if (is_ret) begin
      ret_pulse = 1'b1;
    end else begin
      instr_end = 1'b1;
    end
    @(posedge clk);
    #1;
    instr_end = 1'b0;
    ret_pulse = 1'b0;
  endtask
endmodule

/* tb/interrupt_and_low_power_control_test.sv */
// self-checking bench for the interrupt and low power controller
// assumes ilpc_top and the core partner model
`timescale 1ns/1ps
module interrupt_and_low_power_control_test
  import ilpc_pkg::*;
;
  localparam int STAB = 4;
  logic CORE_CLK, RST, WR_EN, WR_BIT_OP, WAIT_INSTR, STOP_INSTR, FLAG_WR, CARRY_IN, ZERO_IN;
  logic WATCHDOG_ACTIVE, NMI_N, SRC1_PIN_N, SRC2_PIN, INSTR_END, RETURN_FROM_INTERRUPT;
  logic PC_LOAD, CORE_HALT, OSC_STOP, CARRY_OUT, ZERO_OUT;
  logic [7:0] WR_ADDR, WR_DATA, PORT_A_IRQ, PORT_B_IRQ, PORT_C_IRQ;
  logic [11:0] PC_IN, PC_LOAD_VALUE, ev;
  logic [2:0] CORE_MODE;
  int bad_count = 0;
  int n_checks = 0;
  // ****************
  // instances
  // ****************
  ilpc_top #(.STAB_CYCLES(STAB)) u_dut (.CORE_CLK, .RST, .WR_EN, .WR_BIT_OP, .WR_ADDR, .WR_DATA,
    .INSTR_END, .RETURN_FROM_INTERRUPT, .WAIT_INSTR, .STOP_INSTR, .PC_IN, .PC_LOAD_VALUE, .PC_LOAD,
    .CORE_HALT, .OSC_STOP, .FLAG_WR, .CARRY_IN, .ZERO_IN, .CARRY_OUT, .ZERO_OUT, .CORE_MODE,
    .WATCHDOG_ACTIVE, .NMI_N, .SRC1_PIN_N, .SRC2_PIN, .PORT_A_IRQ, .PORT_B_IRQ, .PORT_C_IRQ,
    .TIMER_UNDERFLOW_FLAG(ev[1]), .TIMER_IRQ_ENABLE(ev[0]), .ADC_EOC_FLAG(ev[3]),
    .CONVERTER_IRQ_ENABLE(ev[2]), .RELOAD_TIMER_OVERFLOW_FLAG(ev[5]), .RELOAD_TIMER_OVERFLOW_ENABLE(ev[4]),
    .RELOAD_TIMER_COMPARE_FLAG(ev[7]), .RELOAD_TIMER_COMPARE_ENABLE(ev[6]),
    .RELOAD_TIMER_EDGE_FLAG(ev[9]), .RELOAD_TIMER_EDGE_ENABLE(ev[8]),
    .SERIAL_DONE_FLAG(ev[11]), .SERIAL_IRQ_ENABLE(ev[10]));
  ilpc_core_model u_core (.clk(CORE_CLK), .instr_end(INSTR_END), .ret_pulse(RETURN_FROM_INTERRUPT),
    .pc(PC_IN), .pc_load_value(PC_LOAD_VALUE), .pc_load(PC_LOAD));
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic restart;
    RST = 1'b1;
    tick(5);
    RST = 1'b0;
    tick(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
    WR_EN = 1'b1;
    WR_ADDR = a;
    WR_DATA = d;
    WR_BIT_OP = b;
    tick(1);
    WR_EN = 1'b0;
    WR_BIT_OP = 1'b0;
  endtask
  // instruction end or return, then load, value and mode
  task automatic step(input logic r, input logic ld, input logic [11:0] v, input logic [2:0] m);
    u_core.pulse(r);
    chk(PC_LOAD, ld);
    if (ld) begin
      chk(PC_LOAD_VALUE, v);
    end
    tick(1);
    chk(CORE_MODE, m);
  endtask
  task automatic flg(input logic c, input logic z);
    FLAG_WR = 1'b1;
    CARRY_IN = c;
    ZERO_IN = z;
    tick(1);
    FLAG_WR = 1'b0;
  endtask
  task automatic slp(input logic s);
    STOP_INSTR = s;
    WAIT_INSTR = !s;
    tick(1);
    STOP_INSTR = 1'b0;
    WAIT_INSTR = 1'b0;
  endtask
  task automatic halt_cycles(output int n);
    n = 0;
    while (CORE_HALT !== 1'b0 && n < 40) begin
      tick(1);
      n++;
    end
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_option;
    restart;
    chk(CORE_MODE, 3'h1);
    chk({CORE_HALT, OSC_STOP, PC_LOAD}, 3'h0);
    ev = 12'h003;
    step(1'b0, 1'b0, 12'h000, 3'h1);
    wr(8'hC8, 8'h10, 1'b1);
    step(1'b0, 1'b0, 12'h000, 3'h1);
    wr(8'hC9, 8'h10, 1'b0);
    step(1'b0, 1'b0, 12'h000, 3'h1);
    wr(8'hC8, 8'h8F, 1'b0);
    step(1'b0, 1'b0, 12'h000, 3'h1);
    wr(8'hC8, 8'h10, 1'b0);
    step(1'b0, 1'b1, 12'hFF0, 3'h2);
    ev = 12'h000;
    step(1'b1, 1'b1, 12'h123, 3'h1);
    for (int k = 0; k < 3; k++) begin
      PORT_A_IRQ[0] = (k == 0);
      PORT_B_IRQ[3] = (k == 1);
      PORT_C_IRQ[7] = (k == 2);
      tick(4);
      step(1'b0, 1'b1, (k == 2) ? 12'hFF4 : 12'hFF6, 3'h2);
      PORT_A_IRQ = 8'h00;
      PORT_B_IRQ = 8'h00;
      PORT_C_IRQ = 8'h00;
      tick(4);
      step(1'b1, 1'b1, 12'h123, 3'h1);
    end
  endtask
  task automatic t_events;
    logic [11:0] vt [6];
    vt = '{12'hFF0, 12'hFF0, 12'hFF2, 12'hFF2, 12'hFF2, 12'hFF4};
    restart;
    wr(8'hC8, 8'h10, 1'b0);
    for (int i = 0; i < 6; i++) begin
      ev = 12'h000;
      ev[2*i+1] = 1'b1;
      step(1'b0, 1'b0, 12'h000, 3'h1);
      ev[2*i] = 1'b1;
      step(1'b0, 1'b1, vt[i], 3'h2);
      ev = 12'h000;
      step(1'b1, 1'b1, 12'h123, 3'h1);
    end
  endtask
  task automatic t_nest;
    restart;
    wr(8'hC8, 8'h10, 1'b0);
    flg(1'b1, 1'b1);
    ev = 12'h003;
    step(1'b0, 1'b1, 12'hFF0, 3'h2);
    flg(1'b0, 1'b0);
    chk({CARRY_OUT, ZERO_OUT}, 2'h0);
    PORT_A_IRQ = 8'h01;
    tick(4);
    step(1'b0, 1'b0, 12'h000, 3'h2);
    NMI_N = 1'b0;
    tick(4);
    step(1'b0, 1'b1, 12'hFFC, 3'h4);
    flg(1'b1, 1'b0);
    chk({CARRY_OUT, ZERO_OUT}, 2'h2);
    NMI_N = 1'b1;
    step(1'b1, 1'b1, 12'hFF0, 3'h2);
    chk({CARRY_OUT, ZERO_OUT}, 2'h0);
    ev = 12'h000;
    step(1'b1, 1'b1, 12'h123, 3'h1);
    chk({CARRY_OUT, ZERO_OUT}, 2'h3);
    PORT_A_IRQ = 8'h00;
  endtask
  task automatic t_edges;
    restart;
    wr(8'hC8, 8'h30, 1'b0);
    SRC2_PIN = 1'b1;
    tick(4);
    step(1'b0, 1'b1, 12'hFF4, 3'h2);
    step(1'b1, 1'b1, 12'h123, 3'h1);
    SRC2_PIN = 1'b0;
    tick(4);
    wr(8'hC8, 8'h10, 1'b0);
    SRC2_PIN = 1'b1;
    tick(4);
    step(1'b0, 1'b0, 12'h000, 3'h1);
    SRC2_PIN = 1'b0;
    tick(4);
    step(1'b0, 1'b1, 12'hFF4, 3'h2);
    step(1'b1, 1'b1, 12'h123, 3'h1);
    SRC1_PIN_N = 1'b0;
    tick(4);
    SRC1_PIN_N = 1'b1;
    tick(4);
    step(1'b0, 1'b1, 12'hFF6, 3'h2);
    step(1'b1, 1'b1, 12'h123, 3'h1);
    wr(8'hC8, 8'h50, 1'b0);
    SRC1_PIN_N = 1'b0;
    tick(4);
    SRC1_PIN_N = 1'b1;
    tick(4);
    step(1'b0, 1'b0, 12'h000, 3'h1);
  endtask
  task automatic t_power;
    int n;
    restart;
    wr(8'hC8, 8'h10, 1'b0);
    slp(1'b0);
    tick(3);
    chk({CORE_HALT, OSC_STOP}, 2'h2);
    ev = 12'h003;
    halt_cycles(n);
    chk(n <= 2, 1'b1);
    slp(1'b0);
    tick(1);
    chk(CORE_HALT, 1'b0);
    ev = 12'h000;
    WATCHDOG_ACTIVE = 1'b1;
    slp(1'b1);
    chk({CORE_HALT, OSC_STOP}, 2'h2);
    ev = 12'h003;
    halt_cycles(n);
    chk(n <= 2, 1'b1);
    ev = 12'h000;
    WATCHDOG_ACTIVE = 1'b0;
    slp(1'b1);
    chk({CORE_HALT, OSC_STOP}, 2'h3);
    ev = 12'h003;
    tick(6);
    chk(CORE_HALT, 1'b1);
    ev = 12'h000;
    SRC1_PIN_N = 1'b0;
    halt_cycles(n);
    chk(n >= STAB && n < 40, 1'b1);
    SRC1_PIN_N = 1'b1;
    restart;
    slp(1'b0);
    NMI_N = 1'b0;
    tick(6);
    chk(CORE_HALT, 1'b1);
    restart;
    chk(CORE_HALT, 1'b0);
    NMI_N = 1'b1;
  endtask
  // ****************
  // run
  // ****************
  initial begin
    CORE_CLK = 1'b0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    {RST, WR_EN, WR_BIT_OP, WAIT_INSTR, STOP_INSTR, FLAG_WR, CARRY_IN, ZERO_IN} = 8'h80;
    {WATCHDOG_ACTIVE, SRC2_PIN, WR_ADDR, WR_DATA} = 18'h0_0000;
    {NMI_N, SRC1_PIN_N} = 2'h3;
    {PORT_A_IRQ, PORT_B_IRQ, PORT_C_IRQ, ev} = 36'h0_0000_0000;
    #1;
    t_option;
    t_events;
    t_nest;
    t_edges;
    t_power;
    give_verdict;
  end
  initial begin
    #100000;
    bad_count++;
    give_verdict;
  end
endmodule
